/* File: rtl/arsf_pkg.sv */
/*
 * Package for the converter result and status flag block: widths,
 * reset values and the power-state encoding of the converter core.
 * Assumes one system clock and an active-low asynchronous reset.
 */
package arsf_pkg;

    // ------------------------------------------------------------------
    // Default geometry
    // ------------------------------------------------------------------
    localparam int unsigned NUM_CHAN_DEF = 8;
    localparam int unsigned DATA_W_DEF   = 10;
    localparam int unsigned CHAN_W_DEF   = 3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic FLAG_RST  = 1'b0;
    localparam logic SLEEP_RST = 1'b0;

    // ------------------------------------------------------------------
    // Power state of the converter core
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        PWR_AWAKE,
        PWR_ASLEEP
    } arsf_pwr_e;

endpackage

/* File: rtl/arsf_sleep_ctl.sv */
/*
 * Sleep control: latches the software sleep option only on an end of
 * conversion, so a selection made while idle waits for the next result.
 * Assumes eoc_i is a one-cycle pulse synchronous to clk_sys_i.
 */
`timescale 1ns/1ps

module arsf_sleep_ctl (
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic reset_n_i,
    // Control
    input  wire logic sleep_sel_i,
    input  wire logic eoc_i,
    // Status
    output logic      sleep_active_o
);

    typedef struct packed {
        arsf_pkg::arsf_pwr_e pwr;
    } arsf_sleep_s;

    arsf_sleep_s st_q;
    arsf_sleep_s st_d;

    // ------------------------------------------------------------------
    // Next state: the option is applied only at the end of a conversion
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (eoc_i) begin
            st_d.pwr = sleep_sel_i ? arsf_pkg::PWR_ASLEEP
                                   : arsf_pkg::PWR_AWAKE;
        end
    end

    // State register
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q.pwr <= arsf_pkg::PWR_AWAKE;
        end else begin
            st_q <= st_d;
        end
    end

    assign sleep_active_o = (st_q.pwr == arsf_pkg::PWR_ASLEEP);

    // Sleep may change only on the cycle after an end of conversion
    sleep_hold_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        !eoc_i |=> $stable(sleep_active_o))
        else $error("sleep state changed without end of conversion");

endmodule

/* File: rtl/arsf_status.sv */
/*
 * Result registers and status flags of a converter controller.
 * Assumes the conversion core pulses eoc_i for one cycle with the channel
 * number and data, and the bus side pulses one read strobe per read.
 */
`timescale 1ns/1ps

module arsf_status #(
    parameter int unsigned NUM_CHAN = arsf_pkg::NUM_CHAN_DEF,
    parameter int unsigned DATA_W   = arsf_pkg::DATA_W_DEF,
    parameter int unsigned CHAN_W   = arsf_pkg::CHAN_W_DEF
) (
    // Clock and reset
    input  wire logic                clk_sys_i,
    input  wire logic                reset_n_i,
    // Conversion core
    input  wire logic                eoc_i,
    input  wire logic [CHAN_W-1:0]   eoc_chan_i,
    input  wire logic [DATA_W-1:0]   eoc_data_i,
    // Configuration
    input  wire logic [NUM_CHAN-1:0] chan_en_i,
    input  wire logic                sleep_sel_i,
    // Read side-effect strobes
    input  wire logic                rd_last_i,
    input  wire logic                rd_chan_i,
    input  wire logic [CHAN_W-1:0]   rd_chan_sel_i,
    input  wire logic                rd_status_i,
    // Results
    output logic [DATA_W-1:0]        shared_last_result_o,
    output logic [CHAN_W-1:0]        last_chan_o,
    output logic [NUM_CHAN*DATA_W-1:0] per_channel_result_o,
    // Status
    output logic [NUM_CHAN-1:0]      chan_done_o,
    output logic [NUM_CHAN-1:0]      channel_overrun_flag_o,
    output logic                     data_ready_flag_o,
    output logic                     global_overrun_flag_o,
    output logic                     sleep_active_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_CHAN*DATA_W-1:0] res;
        logic [DATA_W-1:0]          last;
        logic [CHAN_W-1:0]          last_ch;
        logic [NUM_CHAN-1:0]        done;
        logic [NUM_CHAN-1:0]        ovr;
        logic                       data_ready_flag;
        logic                       govr;
    } arsf_state_s;

    arsf_state_s st_q;
    arsf_state_s st_d;

    // One-hot decode of a channel number, used for ends and reads
    function automatic logic [NUM_CHAN-1:0] onehot(
        input logic [CHAN_W-1:0] ch,
        input logic              vld
    );
        logic [NUM_CHAN-1:0] v;
        v = '0;
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (vld && (ch == CHAN_W'(i))) begin
                v[i] = 1'b1;
            end
        end
        return v;
    endfunction

    logic [NUM_CHAN-1:0] eoc_hot;
    logic [NUM_CHAN-1:0] rd_hot;
    logic                eoc_en;

    // Disabled or out-of-range channel ends give an empty one-hot vector
    assign eoc_hot = onehot(eoc_chan_i, eoc_i) & chan_en_i;
    assign rd_hot  = onehot(rd_chan_sel_i, rd_chan_i);
    assign eoc_en  = |eoc_hot;

    // ------------------------------------------------------------------
    // Next state; each flag is cleared first, then set, so sets win
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        // Read-triggered clears
        if (rd_last_i) begin
            st_d.data_ready_flag = 1'b0;
            st_d.done = st_d.done & ~onehot(st_q.last_ch, 1'b1);
        end
        st_d.done = st_d.done & ~rd_hot;
        if (rd_status_i) begin
            st_d.govr = 1'b0;
            st_d.ovr  = '0;
        end
        // Event sets; only enabled ends count, so a disabled end cannot
        // hold data-ready against a coincident last-result read
        if (eoc_en) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (eoc_hot[i]) begin
                    st_d.res[i*DATA_W +: DATA_W] = eoc_data_i;
                    if (st_q.done[i]) begin
                        st_d.ovr[i] = 1'b1;
                    end
                end
            end
            st_d.last    = eoc_data_i;
            st_d.last_ch = eoc_chan_i;
            st_d.done    = st_d.done | eoc_hot;
            st_d.data_ready_flag    = 1'b1;
            if (st_q.data_ready_flag) begin
                st_d.govr = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q.res     <= '0;
            st_q.last    <= '0;
            st_q.last_ch <= '0;
            st_q.done    <= '0;
            st_q.ovr     <= '0;
            st_q.data_ready_flag    <= arsf_pkg::FLAG_RST;
            st_q.govr    <= arsf_pkg::FLAG_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign shared_last_result_o   = st_q.last;
    assign last_chan_o            = st_q.last_ch;
    assign per_channel_result_o   = st_q.res;
    assign chan_done_o            = st_q.done;
    assign channel_overrun_flag_o = st_q.ovr;
    assign data_ready_flag_o      = st_q.data_ready_flag;
    assign global_overrun_flag_o  = st_q.govr;

    // ------------------------------------------------------------------
    // Sleep control; software writes sleep before starting a conversion
    // ------------------------------------------------------------------
    arsf_sleep_ctl u_sleep (
        .clk_sys_i      (clk_sys_i),
        .reset_n_i      (reset_n_i),
        .sleep_sel_i    (sleep_sel_i),
        .eoc_i          (eoc_en),
        .sleep_active_o (sleep_active_o)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence enabled_end_s;
        eoc_i && chan_en_i[eoc_chan_i];
    endsequence

    data_ready_flag_keep_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        data_ready_flag_o && !rd_last_i |=> data_ready_flag_o)
        else $error("data-ready dropped without last-result read");

    data_ready_flag_set_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        enabled_end_s |=> data_ready_flag_o)
        else $error("data-ready not set on enabled end");

    store_last_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        enabled_end_s |=> shared_last_result_o == $past(eoc_data_i))
        else $error("last result not stored");

    dis_nostore_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        eoc_i && !chan_en_i[eoc_chan_i] && rd_last_i
        |=> !data_ready_flag_o && $stable(shared_last_result_o))
        else $error("disabled end affected result or data-ready");

    govr_set_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        enabled_end_s ##0 data_ready_flag_o |=> global_overrun_flag_o)
        else $error("global overrun not raised");

    govr_clr_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        rd_status_i
        && !(eoc_i && chan_en_i[eoc_chan_i] && data_ready_flag_o)
        |=> !global_overrun_flag_o)
        else $error("global overrun not cleared by status read");

    ovr_set_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        enabled_end_s ##0 chan_done_o[eoc_chan_i]
        |=> channel_overrun_flag_o[$past(eoc_chan_i)])
        else $error("channel overrun not raised");

    done_clr_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        rd_chan_i && !rd_last_i && !eoc_i
        |=> (chan_done_o | onehot($past(rd_chan_sel_i), 1'b1))
            == ($past(chan_done_o) | onehot($past(rd_chan_sel_i), 1'b1)))
        else $error("channel read disturbed another done flag");

    // A coincident overrun on the converting channel is the only survivor
    ovr_clr_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        rd_status_i
        && !(eoc_i && chan_en_i[eoc_chan_i] && chan_done_o[eoc_chan_i])
        |=> channel_overrun_flag_o == '0)
        else $error("channel overruns not cleared by status read");

    // Last-result read drops the done flag of the channel it returned
    done_last_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        rd_last_i && !(eoc_i && chan_en_i[eoc_chan_i]
                       && eoc_chan_i == last_chan_o)
        |=> !chan_done_o[$past(last_chan_o)])
        else $error("last-result read left its done flag set");

    // An enabled end always leaves its done flag set, whatever the reads
    done_set_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        enabled_end_s |=> chan_done_o[$past(eoc_chan_i)])
        else $error("done flag lost against a coincident read");

endmodule

/* File: tb/arsf_bus_model.sv */
/*
 * Software side of the processor bus: read strobes and the sleep option.
 * Assumes the bench calls put just after a rising edge and clear one
 * clock later, so each strobe stands for exactly one cycle.
 */
`timescale 1ns/1ps

module arsf_bus_model (
    // Read strobes
    output logic       rd_last_o,
    output logic       rd_chan_o,
    output logic [2:0] rd_chan_sel_o,
    output logic       rd_status_o,
    // Mode
    output logic       sleep_sel_o
);
    // ------------------------------------------------------------------
    // Accesses
    // ------------------------------------------------------------------
    initial begin
        {rd_last_o, rd_chan_o, rd_chan_sel_o, rd_status_o} = 6'h00;
        sleep_sel_o = 1'h0;
    end

    // Done flags of disabled channels are never acted on here
    task automatic put(input logic [2:0] r, input logic [2:0] s);
        {rd_last_o, rd_chan_o, rd_status_o} = r;
        rd_chan_sel_o = s;
    endtask

    // Released select shows another value so a stale one is not trusted
    task automatic clear();
        {rd_last_o, rd_chan_o, rd_status_o} = 3'h0;
        rd_chan_sel_o = ~rd_chan_sel_o;
    endtask

    // Sleep option is written while idle, ahead of the next end of conversion
    task automatic sleep(input logic v);
        sleep_sel_o = v;
    endtask
endmodule

/* File: tb/test_adc_result_status_flags.sv */
/*
 * Directed bench for the result and status flag block.
 * Assumes the bus model above and the default geometry of arsf_pkg.
 */
`timescale 1ns/1ps

module test_adc_result_status_flags;
    localparam int DW = arsf_pkg::DATA_W_DEF;
    logic          clk_sys_i = 1'h0;
    logic          reset_n_i = 1'h0;
    logic          eoc_i = 1'h0;
    logic [2:0]    eoc_chan_i = 3'h0;
    logic [DW-1:0] eoc_data_i = 10'h000;
    logic [7:0]    chan_en_i = 8'hdf;
    logic          rl, rc, rs, ss;
    logic [2:0]    rsel, last_chan_o;
    logic [DW-1:0] shared_last_result_o;
    logic [8*DW-1:0] per_channel_result_o;
    logic [7:0]    chan_done_o, channel_overrun_flag_o;
    logic          data_ready_flag_o, global_overrun_flag_o, sleep_active_o;
    int            fail_count = 0;
    int            cmp_count = 0;
    int            cycles = 0;

    // ------------------------------------------------------------------
    // Design and partner
    // ------------------------------------------------------------------
    arsf_status i_arsf_status (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .eoc_i(eoc_i), .eoc_chan_i(eoc_chan_i), .eoc_data_i(eoc_data_i),
        .chan_en_i(chan_en_i), .sleep_sel_i(ss), .rd_last_i(rl),
        .rd_chan_i(rc), .rd_chan_sel_i(rsel), .rd_status_i(rs),
        .shared_last_result_o(shared_last_result_o),
        .last_chan_o(last_chan_o),
        .per_channel_result_o(per_channel_result_o),
        .chan_done_o(chan_done_o),
        .channel_overrun_flag_o(channel_overrun_flag_o),
        .data_ready_flag_o(data_ready_flag_o),
        .global_overrun_flag_o(global_overrun_flag_o),
        .sleep_active_o(sleep_active_o));
    arsf_bus_model i_arsf_bus_model (.rd_last_o(rl), .rd_chan_o(rc),
        .rd_chan_sel_o(rsel), .rd_status_o(rs), .sleep_sel_o(ss));

    // Clock and a hang guard well above the directed run length
    always #2 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 500) begin
            fail_count++;
            test_done();
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic test_done();
        if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // Done, data-ready, global overrun, channel overruns in one word
    task automatic chk_f(input logic [7:0] d, input logic r, input logic g,
                         input logic [7:0] o);
        chk("flags", {d, r, g, o}, {chan_done_o, data_ready_flag_o,
            global_overrun_flag_o, channel_overrun_flag_o});
    endtask

    function automatic logic [DW-1:0] res(input int i);
        return per_channel_result_o[i*DW +: DW];
    endfunction

    // One request cycle with optional end and reads {last, chan, status},
    // then one idle cycle so no strobe falls and rises in one time step
    task automatic st(input logic e, input logic [2:0] c,
                      input logic [DW-1:0] d, input logic [2:0] r,
                      input logic [2:0] s);
        eoc_i = e;
        eoc_chan_i = c;
        eoc_data_i = d;
        i_arsf_bus_model.put(r, s);
        @(posedge clk_sys_i);
        #1;
        eoc_i = 1'h0;
        eoc_data_i = ~d;
        i_arsf_bus_model.clear();
        @(posedge clk_sys_i);
        #1;
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_sys_i);
        #1 reset_n_i = 1'h1;
        chk_f(8'h00, 1'h0, 1'h0, 8'h00);
        st(1'h1, 3'h2, 10'h3a1, 3'h0, 3'h0);
        chk_f(8'h04, 1'h1, 1'h0, 8'h00);
        chk("res", {3'h2, 10'h3a1, 10'h3a1},
            {last_chan_o, shared_last_result_o, res(2)});
        st(1'h0, 3'h0, 10'h000, 3'h2, 3'h2);
        chk_f(8'h00, 1'h1, 1'h0, 8'h00);
        st(1'h1, 3'h2, 10'h155, 3'h0, 3'h0);
        chk_f(8'h04, 1'h1, 1'h1, 8'h00);
        st(1'h1, 3'h2, 10'h2aa, 3'h0, 3'h0);
        chk_f(8'h04, 1'h1, 1'h1, 8'h04);
        st(1'h1, 3'h3, 10'h0f0, 3'h1, 3'h0);
        chk_f(8'h0c, 1'h1, 1'h1, 8'h00);
        st(1'h0, 3'h0, 10'h000, 3'h4, 3'h0);
        chk_f(8'h04, 1'h0, 1'h1, 8'h00);
        st(1'h0, 3'h0, 10'h000, 3'h1, 3'h0);
        chk_f(8'h04, 1'h0, 1'h0, 8'h00);
        st(1'h1, 3'h1, 10'h011, 3'h0, 3'h0);
        chk_f(8'h06, 1'h1, 1'h0, 8'h00);
        st(1'h1, 3'h5, 10'h3ff, 3'h4, 3'h0);
        chk_f(8'h04, 1'h0, 1'h0, 8'h00);
        chk("keep", {10'h011, 10'h000},
            {shared_last_result_o, res(5)});
        st(1'h1, 3'h4, 10'h044, 3'h0, 3'h0);
        st(1'h1, 3'h6, 10'h066, 3'h0, 3'h0);
        chk_f(8'h54, 1'h1, 1'h1, 8'h00);
        st(1'h0, 3'h0, 10'h000, 3'h5, 3'h0);
        chk_f(8'h14, 1'h0, 1'h0, 8'h00);
        st(1'h1, 3'h0, 10'h100, 3'h2, 3'h7);
        chk_f(8'h15, 1'h1, 1'h0, 8'h00);
        // Channel 1 is disabled in the very cycle of the channel 0 end
        chan_en_i = 8'hdd;
        st(1'h1, 3'h0, 10'h101, 3'h0, 3'h0);
        chk_f(8'h15, 1'h1, 1'h1, 8'h01);
        chan_en_i = 8'hdf;
        st(1'h0, 3'h0, 10'h000, 3'h2, 3'h0);
        chk_f(8'h14, 1'h1, 1'h1, 8'h01);
        st(1'h1, 3'h0, 10'h102, 3'h1, 3'h0);
        chk_f(8'h15, 1'h1, 1'h1, 8'h00);
        // End and read of the same channel together: the set must win
        st(1'h1, 3'h2, 10'h222, 3'h2, 3'h2);
        chk_f(8'h15, 1'h1, 1'h1, 8'h04);
        i_arsf_bus_model.sleep(1'h1);
        repeat (3) st(1'h0, 3'h0, 10'h000, 3'h0, 3'h0);
        chk("sleep", 1'h0, sleep_active_o);
        st(1'h1, 3'h1, 10'h033, 3'h0, 3'h0);
        chk("sleep", 1'h1, sleep_active_o);
        test_done();
    end
endmodule
